// >>> hw/power_fail_stop_control.sv
// Purpose: Power-fail monitor, stop mode and reset sequencer with APB registers.
// Assumes: Supply comparators arrive as synchronous levels.
// Notes:   Analog switching is reported as enable outputs.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "pfs_map.svh"

module power_fail_stop_control
	import pfs_pkg::*;
#(
	parameter int XTAL_WARMUP = `XTAL_WARMUP_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Supply comparators
	input  wire logic        usb_above_3v0,
	input  wire logic        usb_above_battery,
	input  wire logic        battery_present,
	input  wire logic        above_por,
	input  wire logic        above_reset,
	input  wire logic        above_warn,
	// Other reset sources and wake events
	input  wire logic        ext_reset_n,
	input  wire logic        watchdog_reset,
	input  wire logic        io_irq,
	// Analog and CPU controls
	output logic             use_usb_supply,
	output warn_level_t      warn_threshold,
	output logic             monitor_on,
	output logic             regulator_on,
	output logic             crystal_on,
	output logic             cpu_reset,
	output logic             cpu_halt,
	output logic [15:0]      resume_addr,
	output logic             warn_irq
);
	import pfs_pkg::*;

	// ==========================================================================
	// Declarations
	seq_state_e    state_reg;
	seq_state_e    state_next;
	logic          stop_monitor_disable;
	warn_level_t   warn_level_select;
	logic [1:0]    period_sel_reg;
	logic          stop_req_reg;
	logic          warn_irq_enable;
	logic          warn_irq_flag;
	logic [15:0]   interval_reg;
	logic [15:0]   warm_cnt_reg;
	logic [13:0]   per_cnt_reg;
	logic [1:0]    good_cnt_reg;
	logic [9:0]    qual_cnt_reg;
	logic          por_seen_reg;
	logic          wr_en;
	logic          rd_en;
	logic          mon_active;
	logic          warn_cond;
	logic          warn_qual;
	logic          soft_reset;
	logic [31:0]   rd_mux;
	ring_tick_if   rt ();

	// ==========================================================================
	// Helpers
	function automatic logic [13:0] period_len(input logic [1:0] sel);
		case (sel)
			2'h1:    period_len = 14'h0800;
			2'h2:    period_len = 14'h1000;
			2'h3:    period_len = 14'h2000;
			default: period_len = 14'h0000;
		endcase
	endfunction

	ring_divider u_div (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.tick    (rt.tick)
	);

	wake_timer u_wake (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.rt      (rt)
	);

	assign wr_en      = psel && penable && pwrite;
	assign rd_en      = psel && penable && !pwrite;
	assign soft_reset = !ext_reset_n || watchdog_reset;
	// A supply below reset is also below warning, so one count qualifies both events.
	assign warn_cond  = (!above_warn || !above_reset) &&
	                    !(use_usb_supply && battery_present);
	// Monitor live in run, warm-up, soft reset, and in stop unless disabled.
	assign mon_active = (state_reg != ST_STOP) || !stop_monitor_disable;
	assign warn_qual  = qual_cnt_reg == 10'(`WARN_QUALIFY_CYC);

	// ==========================================================================
	// Supply switch
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			use_usb_supply <= 1'b0;
		end else begin
			use_usb_supply <= usb_above_3v0 || usb_above_battery;
		end
	end

	// ==========================================================================
	// Power-on record: only a power-on clears the warning level.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			por_seen_reg <= 1'b1;
		end else begin
			por_seen_reg <= !above_por;
		end
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			warn_level_select <= `WARN_LVL_RST;
		end else if (por_seen_reg) begin
			warn_level_select <= `WARN_LVL_RST;
		end else if (wr_en && paddr == `POWER_CONTROL_OFS) begin
			warn_level_select <= pwdata[`PC_WARN_LVL_HI:`PC_WARN_LVL_LO];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stop_monitor_disable <= `STOP_MON_DIS_RST;
			period_sel_reg       <= `PERIOD_SEL_RST;
			warn_irq_enable      <= 1'b0;
			interval_reg         <= `WAKE_INTERVAL_RST;
		end else if (soft_reset || cpu_reset) begin
			stop_monitor_disable <= `STOP_MON_DIS_RST;
			warn_irq_enable      <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`POWER_CONTROL_OFS: begin
					stop_monitor_disable <= pwdata[`PC_STOP_MON_DIS];
					period_sel_reg       <= pwdata[`PC_PER_HI:`PC_PER_LO];
				end
				`CLOCK_CONTROL_OFS: begin
					warn_irq_enable <= pwdata[`CC_WARN_IRQ_EN];
				end
				`WAKE_INTERVAL_OFS: begin
					interval_reg <= pwdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stop_req_reg <= 1'b0;
		end else if (wr_en && paddr == `POWER_CONTROL_OFS) begin
			stop_req_reg <= pwdata[`PC_STOP_REQ];
		end else begin
			stop_req_reg <= 1'b0;
		end
	end

	// ==========================================================================
	// Warning qualification
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			qual_cnt_reg <= 10'h000;
		end else if (!warn_cond || !mon_active) begin
			qual_cnt_reg <= 10'h000;
		end else if (!warn_qual) begin
			qual_cnt_reg <= qual_cnt_reg + 10'h001;
		end
	end

	// Set wins over a software clear in the same cycle.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			warn_irq_flag <= 1'b0;
		end else if (warn_qual && above_reset &&
		             (state_reg == ST_RUN || state_reg == ST_STOP)) begin
			warn_irq_flag <= 1'b1;
		end else if (wr_en && paddr == `STATUS_OFS && pwdata[`ST_WARN_FLAG]) begin
			warn_irq_flag <= 1'b0;
		end
	end

	// ==========================================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_POR: begin
				if (above_por) state_next = ST_WARMUP;
			end
			ST_WARMUP: begin
				if (!above_por) state_next = ST_POR;
				else if (warm_cnt_reg == 16'(XTAL_WARMUP) && above_reset) state_next = ST_RUN;
			end
			ST_RUN: begin
				if (!above_por) state_next = ST_POR;
				else if (!above_reset && warn_qual) state_next = ST_PFAIL;
				else if (soft_reset) state_next = ST_SOFT;
				else if (stop_req_reg) state_next = ST_STOP;
			end
			ST_STOP: begin
				if (!above_por) state_next = ST_POR;
				else if (mon_active && !above_reset && warn_qual) state_next = ST_PFAIL;
				else if (io_irq || rt.wake || (warn_qual && warn_irq_enable)) state_next = ST_WAKE;
			end
			ST_WAKE: begin
				if (!above_por) state_next = ST_POR;
				else if (!above_reset) state_next = ST_PFAIL;
				else if (warm_cnt_reg == 16'(XTAL_WARMUP)) state_next = ST_RUN;
			end
			ST_PFAIL: begin
				if (!above_por) state_next = ST_POR;
				else if (good_cnt_reg == 2'(`DETECT_ON_TICKS + 1)) state_next = ST_WARMUP;
			end
			ST_SOFT: begin
				if (!above_por) state_next = ST_POR;
				else if (!soft_reset && warm_cnt_reg == 16'(`EXT_RESET_CYC - 1)) state_next = ST_RUN;
			end
			default: state_next = ST_POR;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// Warm-up and soft-reset release counter.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			warm_cnt_reg <= 16'h0000;
		end else if (state_next != state_reg || (state_reg == ST_SOFT && soft_reset)) begin
			warm_cnt_reg <= 16'h0000;
		end else if (warm_cnt_reg != 16'hFFFF) begin
			warm_cnt_reg <= warm_cnt_reg + 16'h0001;
		end
	end

	// ==========================================================================
	// Periodic detection while in power-fail reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			per_cnt_reg  <= 14'h0000;
			good_cnt_reg <= 2'h0;
		end else if (state_reg != ST_PFAIL) begin
			per_cnt_reg  <= 14'h0000;
			good_cnt_reg <= 2'h0;
		end else if (rt.tick) begin
			if (per_cnt_reg >= period_len(period_sel_reg) && !above_reset) begin
				per_cnt_reg  <= 14'h0000;
				good_cnt_reg <= 2'h0;
			end else begin
				if (per_cnt_reg != 14'h3FFF) per_cnt_reg <= per_cnt_reg + 14'h0001;
				if (per_cnt_reg >= period_len(period_sel_reg) && above_reset)
					good_cnt_reg <= good_cnt_reg + 2'h1;
			end
		end
	end

	// ==========================================================================
	// Analog and CPU controls
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			monitor_on   <= 1'b0;
			regulator_on <= 1'b0;
			crystal_on   <= 1'b0;
			cpu_reset    <= 1'b1;
			cpu_halt     <= 1'b0;
			resume_addr  <= `RESUME_ADDR;
		end else begin
			case (state_next)
				ST_POR: begin
					monitor_on   <= 1'b0;
					regulator_on <= 1'b0;
					crystal_on   <= 1'b0;
					cpu_reset    <= 1'b1;
					cpu_halt     <= 1'b0;
				end
				ST_PFAIL: begin
					// Window is the last two ticks before the period runs out.
					monitor_on   <= period_len(period_sel_reg) == 14'h0000 ||
					                per_cnt_reg + 14'(`DETECT_ON_TICKS) >=
					                period_len(period_sel_reg);
					regulator_on <= 1'b0;
					crystal_on   <= 1'b0;
					cpu_reset    <= 1'b1;
					cpu_halt     <= 1'b0;
				end
				ST_STOP: begin
					monitor_on   <= !stop_monitor_disable;
					regulator_on <= 1'b0;
					crystal_on   <= 1'b0;
					cpu_reset    <= 1'b0;
					cpu_halt     <= 1'b1;
				end
				ST_WAKE: begin
					monitor_on   <= 1'b1;
					regulator_on <= 1'b1;
					crystal_on   <= 1'b1;
					cpu_reset    <= 1'b0;
					cpu_halt     <= 1'b1;
				end
				ST_RUN: begin
					monitor_on   <= 1'b1;
					regulator_on <= 1'b1;
					crystal_on   <= 1'b1;
					cpu_reset    <= 1'b0;
					cpu_halt     <= 1'b0;
				end
				default: begin
					monitor_on   <= 1'b1;
					regulator_on <= 1'b1;
					crystal_on   <= 1'b1;
					cpu_reset    <= 1'b1;
					cpu_halt     <= 1'b0;
				end
			endcase
			resume_addr <= `RESUME_ADDR;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			warn_threshold <= `WARN_LVL_RST;
			warn_irq       <= 1'b0;
		end else begin
			warn_threshold <= warn_level_select;
			warn_irq       <= warn_irq_flag && warn_irq_enable;
		end
	end

	assign rt.run      = state_reg == ST_STOP;
	assign rt.interval = interval_reg;

	// ==========================================================================
	// APB slave: zero wait states, reads above STATUS2_OFS return zero with an error.
	always_comb begin
		case (paddr)
			`POWER_CONTROL_OFS: rd_mux = {27'h0, period_sel_reg, warn_level_select,
			                              stop_monitor_disable};
			`CLOCK_CONTROL_OFS: rd_mux = {31'h0, warn_irq_enable};
			`WAKE_INTERVAL_OFS: rd_mux = {16'h0, interval_reg};
			`STATUS_OFS:        rd_mux = {31'h0, warn_irq_flag};
			`STATUS2_OFS:       rd_mux = {25'h0, state_reg};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr <= psel && !penable && paddr > `STATUS2_OFS;
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule

// >>> hw/pfs_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: 50 MHz system clock, 8 kHz ring oscillator enable.
// Notes:   Definitions only.
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define POWER_CONTROL_OFS  12'h000
`define CLOCK_CONTROL_OFS  12'h004
`define WAKE_INTERVAL_OFS  12'h008
`define STATUS_OFS         12'h00C
`define STATUS2_OFS        12'h010

// ==========================================================================
// Field positions
`define PC_STOP_MON_DIS    0
`define PC_WARN_LVL_LO     1
`define PC_WARN_LVL_HI     2
`define PC_PER_LO          3
`define PC_PER_HI          4
`define PC_STOP_REQ        5
`define CC_WARN_IRQ_EN     0
`define ST_WARN_FLAG       0

// ==========================================================================
// Reset values
`define STOP_MON_DIS_RST   1'b1
`define WARN_LVL_RST       2'h0
`define PERIOD_SEL_RST     2'h0
`define WAKE_INTERVAL_RST  16'h0000

// ==========================================================================
// Timing
`define CLK_HZ             50000000
`define RING_HZ            8000
`define WARN_QUALIFY_NS    10000
`define WARN_QUALIFY_CYC   ((`WARN_QUALIFY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RING_DIV_CYC       (`CLK_HZ / `RING_HZ)
`define XTAL_WARMUP_CYC    8192
`define EXT_RESET_CYC      20
`define DETECT_ON_TICKS    2
`define RESUME_ADDR        16'h8000

`endif

// >>> hw/pfs_pkg.sv
// Purpose: Types shared by the power-fail and stop control files.
// Assumes: Nothing.
// Notes:   One-hot state codes.
package pfs_pkg;

	// ==========================================================================
	// Sequencer states
	typedef enum logic [6:0] {
		ST_POR    = 7'h01,
		ST_WARMUP = 7'h02,
		ST_RUN    = 7'h04,
		ST_STOP   = 7'h08,
		ST_WAKE   = 7'h10,
		ST_PFAIL  = 7'h20,
		ST_SOFT   = 7'h40
	} seq_state_e;

	// Supply comparison result.
	typedef struct packed {
		logic above_por;
		logic above_reset;
		logic above_warn;
	} supply_level_s;

	typedef logic [1:0] warn_level_t;

endpackage

// >>> hw/ring_tick_if.sv
// Purpose: Carries the ring oscillator tick and wake timer controls.
// Assumes: One clock domain.
// Notes:   Used between the sequencer and the wake timer.
`timescale 1ns/1ns
interface ring_tick_if;
	logic        tick;
	logic        run;
	logic [15:0] interval;
	logic        wake;

	modport timer (input tick, input run, input interval, output wake);
	modport ctrl  (output run, output interval, input wake, input tick);
endinterface

// >>> hw/ring_divider.sv
// Purpose: Makes the 8 kHz ring oscillator tick as a one-cycle enable.
// Assumes: sys_clk at 50 MHz.
// Notes:   Runs in every state so periodic checks keep their pace.
`timescale 1ns/1ns
`include "pfs_map.svh"
module ring_divider #(
	parameter int DIV = `RING_DIV_CYC
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Tick
	output logic      tick
);
	logic [15:0] cnt_reg;

	// ==========================================================================
	// Divider
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 16'h0000;
			tick    <= 1'b0;
		end else if (cnt_reg == 16'(DIV - 1)) begin
			cnt_reg <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick    <= 1'b0;
		end
	end
endmodule

// >>> hw/wake_timer.sv
// Purpose: Wake-up timer counting ring ticks during stop mode.
// Assumes: Interval in 125 us steps.
// Notes:   A zero interval never wakes.
`timescale 1ns/1ns
module wake_timer (
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  rstn,
	// Control
	ring_tick_if.timer rt
);
	logic [15:0] count_reg;
	logic        fired_reg;

	// ==========================================================================
	// Counter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 16'h0000;
			fired_reg <= 1'b0;
			rt.wake   <= 1'b0;
		end else if (!rt.run) begin
			count_reg <= 16'h0000;
			fired_reg <= 1'b0;
			rt.wake   <= 1'b0;
		end else begin
			rt.wake <= 1'b0;
			if (rt.tick && !fired_reg) begin
				if (count_reg + 16'h0001 == rt.interval && rt.interval != 16'h0000) begin
					rt.wake   <= 1'b1;
					fired_reg <= 1'b1;
				end
				count_reg <= count_reg + 16'h0001;
			end
		end
	end
endmodule

// >>> verification/power_fail_stop_control_checker.sv
// Purpose: Port assertions for the power-fail and stop controller.
// Assumes: One clock; reset asynchronous, active low.
// Notes:   Bound to the controller below the module.
`timescale 1ns/1ns
module pfs_checker #(
	parameter int XTAL_WARMUP = 16
) (
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rstn,
	// Bus
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Supply and reset sources
	input wire logic                 usb_above_3v0,
	input wire logic                 usb_above_battery,
	input wire logic                 above_por,
	input wire logic                 above_reset,
	input wire logic                 ext_reset_n,
	input wire logic                 watchdog_reset,
	// Controls
	input wire logic                 use_usb_supply,
	input wire pfs_pkg::warn_level_t warn_threshold,
	input wire logic                 monitor_on,
	input wire logic                 regulator_on,
	input wire logic                 crystal_on,
	input wire logic                 cpu_reset,
	input wire logic                 cpu_halt,
	input wire logic [15:0]          resume_addr
);
	import pfs_pkg::*;

	// ==========================================================================
	// Helper logic
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// Counts a running low supply; a halted core may have its monitor off.
	logic [10:0] low_cnt;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			low_cnt <= 11'h000;
		else if (above_reset || !above_por || cpu_halt)
			low_cnt <= 11'h000;
		else if (low_cnt != 11'h7FF)
			low_cnt <= low_cnt + 11'h001;
	end

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_write_ctrl;
		psel && penable && pwrite && pready && paddr == 12'h000 && above_por;
	endsequence
	sequence s_soft_hold;
		(!ext_reset_n || watchdog_reset) && above_por && above_reset;
	endsequence
	sequence s_soft_end;
		ext_reset_n && !watchdog_reset && (!$past(ext_reset_n) || $past(watchdog_reset));
	endsequence

	// ==========================================================================
	// Assertions
	a_ready_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (psel && !penable && paddr > 12'h010 |=> pslverr && pready)
		else $error("unmapped access without error");
	a_usb_select: assert property (1'b1 |=> use_usb_supply == ($past(usb_above_3v0) || $past(usb_above_battery)))
		else $error("supply selection wrong");
	a_level_write: assert property (s_write_ctrl |-> ##2 warn_threshold == $past(pwdata[2:1], 2))
		else $error("warning level not applied");
	a_level_soft: assert property (s_soft_hold |=> $stable(warn_threshold))
		else $error("warning level changed by soft reset");
	a_por_clear: assert property (!above_por [*4] |-> warn_threshold == 2'h0)
		else $error("warning level kept through power-on");
	a_por_off: assert property (!above_por [*4] |-> cpu_reset && !monitor_on && !regulator_on && !crystal_on)
		else $error("not all off below power-on level");
	a_pfail_off: assert property (low_cnt == 11'h258 |-> cpu_reset && !regulator_on && !crystal_on)
		else $error("power fail not entered");
	a_soft_keep: assert property (s_soft_hold [*3] |-> cpu_reset && regulator_on && crystal_on)
		else $error("soft reset state wrong");
	a_soft_release: assert property (s_soft_end ##0 (above_reset && above_por) |-> ##[1:22] !cpu_reset)
		else $error("soft reset release late");
	a_resume_addr: assert property (resume_addr == 16'h8000)
		else $error("resume address wrong");
endmodule

bind power_fail_stop_control pfs_checker #(.XTAL_WARMUP(XTAL_WARMUP)) u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.usb_above_3v0(usb_above_3v0), .usb_above_battery(usb_above_battery),
	.above_por(above_por), .above_reset(above_reset), .ext_reset_n(ext_reset_n),
	.watchdog_reset(watchdog_reset), .use_usb_supply(use_usb_supply),
	.warn_threshold(warn_threshold), .monitor_on(monitor_on), .regulator_on(regulator_on),
	.crystal_on(crystal_on), .cpu_reset(cpu_reset), .cpu_halt(cpu_halt),
	.resume_addr(resume_addr));

// >>> verification/power_fail_stop_control_tb.sv
// Purpose: Self-checking bench for the power-fail and stop controller.
// Assumes: Ring tick every 6250 cycles; short crystal warmup.
// Notes:   Bus results are queued and checked by a monitor.
`timescale 1ns/1ns
module power_fail_stop_control_tb;
	import pfs_pkg::*;
	localparam int XW = 16;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        usb_above_3v0 = 1'b0;
	logic        usb_above_battery = 1'b0;
	logic        battery_present = 1'b1;
	logic        above_por = 1'b1;
	logic        above_reset = 1'b1;
	logic        above_warn = 1'b1;
	logic        ext_reset_n = 1'b1;
	logic        watchdog_reset = 1'b0;
	logic        io_irq = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, use_usb_supply, monitor_on, regulator_on;
	logic        crystal_on, cpu_reset, cpu_halt, warn_irq;
	warn_level_t warn_threshold;
	logic [15:0] resume_addr;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] rv;
	int          err_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          seed = 15;
	int          n;

	always #10 sys_clk = ~sys_clk;

	power_fail_stop_control #(.XTAL_WARMUP(XW)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_above_3v0(usb_above_3v0), .usb_above_battery(usb_above_battery),
		.battery_present(battery_present), .above_por(above_por), .above_reset(above_reset),
		.above_warn(above_warn), .ext_reset_n(ext_reset_n), .watchdog_reset(watchdog_reset),
		.io_irq(io_irq), .use_usb_supply(use_usb_supply), .warn_threshold(warn_threshold),
		.monitor_on(monitor_on), .regulator_on(regulator_on), .crystal_on(crystal_on),
		.cpu_reset(cpu_reset), .cpu_halt(cpu_halt), .resume_addr(resume_addr),
		.warn_irq(warn_irq));

	// ==========================================================================
	// Tasks
	task automatic close_out;
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic hold(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// Request stays put until pready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [33:0] x);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(x);
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50)
			err_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {2'b00, 32'h0});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, {2'b10, x});
	endtask

	// Waits a bounded time for cpu_reset (sel 0) or cpu_halt (sel 1) to fall.
	task automatic wait_low(input int sel, input int lim);
		n = 0;
		while ((sel == 0 ? cpu_reset : cpu_halt) !== 1'b0 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk(n < lim, 32'h1);
	endtask

	// ==========================================================================
	// Monitor and timeout
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33])
				chk(prdata, e[31:0]);
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			close_out();
		end
	end

	// ==========================================================================
	// Main sequence
	initial begin
		hold(20);
		rstn <= 1'b1;
		wait_low(0, XW + 200);
		chk(monitor_on, 32'h1);
		rd(12'h000, 32'h1);
		rd(12'h004, 32'h0);
		rd(12'h00C, 32'h0);
		rd(12'h010, 32'h4);
		apb(1'b0, 12'h014, 32'h0, {2'b11, 32'h0});
		rv = $random(seed);
		wr(12'h008, rv);
		rd(12'h008, {16'h0, rv[15:0]});
		for (int i = 0; i < 4; i++) begin
			usb_above_3v0 <= i[0];
			usb_above_battery <= i[1];
			hold(3);
			chk(use_usb_supply, i != 0);
		end
		usb_above_3v0 <= 1'b0;
		usb_above_battery <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(12'h000, i * 10);
			rd(12'h000, i * 10);
			hold(2);
			chk({30'h0, warn_threshold}, i);
		end
		wr(12'h000, 32'h6);
		for (int s = 0; s < 2; s++) begin
			wr(12'h004, 32'h1);
			ext_reset_n <= (s != 0);
			watchdog_reset <= (s != 0);
			hold(5);
			chk({cpu_reset, regulator_on, crystal_on}, 32'h7);
			ext_reset_n <= 1'b1;
			watchdog_reset <= 1'b0;
			wait_low(0, 23);
			rd(12'h000, 32'h7);
			rd(12'h004, 32'h0);
		end
		wr(12'h004, 32'h1);
		above_warn <= 1'b0;
		hold(400);
		above_warn <= 1'b1;
		hold(5);
		chk(warn_irq, 32'h0);
		above_warn <= 1'b0;
		hold(520);
		chk(warn_irq, 32'h1);
		above_warn <= 1'b1;
		rd(12'h00C, 32'h1);
		wr(12'h00C, 32'h1);
		hold(3);
		chk(warn_irq, 32'h0);
		usb_above_3v0 <= 1'b1;
		above_warn <= 1'b0;
		hold(600);
		chk(warn_irq, 32'h0);
		battery_present <= 1'b0;
		hold(520);
		chk(warn_irq, 32'h1);
		battery_present <= 1'b1;
		above_warn <= 1'b1;
		usb_above_3v0 <= 1'b0;
		wr(12'h00C, 32'h1);
		wr(12'h008, 32'h2);
		wr(12'h000, 32'h27);
		hold(4);
		chk(cpu_halt, 32'h1);
		hold(6190);
		chk(cpu_halt, 32'h1);
		wait_low(1, 6600 + XW);
		rd(12'h010, 32'h4);
		wr(12'h008, 32'h0);
		wr(12'h000, 32'h27);
		hold(2);
		above_reset <= 1'b0;
		above_warn <= 1'b0;
		hold(600);
		chk({cpu_reset, monitor_on}, 32'h0);
		above_reset <= 1'b1;
		above_warn <= 1'b1;
		io_irq <= 1'b1;
		wait_low(1, 200);
		io_irq <= 1'b0;
		rd(12'h00C, 32'h0);
		above_reset <= 1'b0;
		hold(600);
		chk({cpu_reset, regulator_on, crystal_on}, 32'h4);
		above_reset <= 1'b1;
		hold(12000);
		chk(cpu_reset, 32'h1);
		wait_low(0, 20000);
		chk(resume_addr, 32'h8000);
		chk({30'h0, warn_threshold}, 32'h3);
		above_por <= 1'b0;
		above_reset <= 1'b0;
		hold(10);
		chk({cpu_reset, monitor_on, regulator_on, crystal_on, warn_threshold}, 32'h20);
		above_por <= 1'b1;
		above_reset <= 1'b1;
		wait_low(0, 20000);
		rd(12'h000, 32'h1);
		hold(3);
		close_out();
	end
endmodule
